// file: uec_defs.svh
// offsets, field positions and limits of the usb endpoint control block
`ifndef UEC_DEFS_SVH
`define UEC_DEFS_SVH
`define UEC_OFF_INT_FLAG 8'h00
`define UEC_OFF_INT_EN   8'h04
`define UEC_OFF_ADDR     8'h08
`define UEC_OFF_FNUM_H   8'h0C
`define UEC_OFF_FNUM_L   8'h10
`define UEC_OFF_FERR     8'h14
`define UEC_OFF_SEL      8'h18
`define UEC_OFF_FIFO_RST 8'h1C
`define UEC_OFF_EP_CTL   8'h20
`define UEC_OFF_EP_CFG0  8'h24
`define UEC_OFF_EP_CFG1  8'h28
`define UEC_OFF_EP_STA   8'h2C
`define UEC_OFF_EP_IEN   8'h30
`define UEC_NUM_EP       5
`define UEC_EP_MAX       3'h4
`define UEC_SOF_BIT      2
`define UEC_SUSP_BIT     0
`define UEC_ADDRESS_ENABLE_BIT    7
`define UEC_FRAME_COUNT_ERROR_BIT   4
`define UEC_STALL_REQUEST_BIT  5
`define UEC_STALLRC_BIT  4
`define UEC_TOGGLE_RESTART_BIT    3
`define UEC_ENDPOINT_ON_BIT     0
`define UEC_ENDPOINT_MEMORY_ALLOCATE_BIT    1
`define UEC_CONFIGURATION_VALID_BIT    7
`define UEC_OVF_BIT      6
`define UEC_UNF_BIT      5
`define UEC_FLOW_ERROR_IRQ_ENABLE_BIT   7
`define UEC_EP0_CAP      9'h040
`define UEC_EPN_CAP      9'h080
`define UEC_RESP_OK      2'h0
`define UEC_RESP_ERR     2'h2
`endif

// file: uec_pkg.sv
// types and the fifo fit check of the usb endpoint control block
`include "uec_defs.svh"
package uec_pkg;
   typedef enum logic {UEC_W_IDLE = 1'b0, UEC_W_RESP = 1'b1} uec_wph_e;
   typedef enum logic [1:0] {UEC_CTRL = 2'b00, UEC_ISO = 2'b01,
      UEC_BULK = 2'b10, UEC_INTR = 2'b11} uec_kind_e;
   typedef struct packed {
      uec_wph_e   wph;
      logic       aw_ok;
      logic       w_ok;
      logic [7:0] awaddr;
      logic [7:0] wdata;
      logic       wstb;
      logic [1:0] bresp;
      logic       rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic       frame_start_irq_enable;
      logic       suspend_irq_enable;
      logic       susp;
      logic       address_enable;
      logic [6:0] addr;
      logic [2:0] sel;
      logic [4:0] frst;
   } uec_top_s;
   typedef struct packed {
      logic       stall;
      logic       on;
      uec_kind_e  kind;
      logic       dir;
      logic [2:0] size;
      logic [1:0] bk;
      logic       endpoint_memory_allocate;
      logic       configuration_valid;
      logic       ovf;
      logic       unf;
      logic       tog;
      logic       flow_error_irq_enable;
      logic       rel;
   } uec_ep_s;
   typedef struct packed {
      logic [10:0] frame;
      logic        sof;
      logic        err;
   } uec_frm_s;
   // size code 0..3 is 8..64 bytes, bank code 0/1 is one/two banks
   function automatic logic uec_fits(input logic [2:0] size,
                                     input logic [1:0] bk,
                                     input logic       ep0);
      logic [8:0] need;
      need = (9'h008 << size[1:0]) << bk[0];
      return !size[2] && !bk[1] && !(ep0 && bk[0]) &&
             (need <= (ep0 ? `UEC_EP0_CAP : `UEC_EPN_CAP));
   endfunction
endpackage

// file: uec_frame.sv
// frame number capture with start-of-frame and frame error flags
`timescale 1ns/1ps
`include "uec_defs.svh"
module uec_frame
   import uec_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        sof_i,
   input  wire logic [10:0] frame_i,
   input  wire logic        crc_err_i,
   input  wire logic        clr_sof_i,
   input  wire logic        clr_err_i,
   output logic      [10:0] frame_o,
   output logic             sof_o,
   output logic             err_o
);
   uec_frm_s q_reg;
   uec_frm_s q_next;

   // clears first so a same-cycle packet wins
   always_comb
   begin
      q_next = q_reg;
      if (clr_sof_i)
         q_next.sof = 1'b0;
      if (clr_err_i)
         q_next.err = 1'b0;
      if (sof_i)
      begin
         q_next.frame = frame_i;
         q_next.sof   = 1'b1;
         q_next.err   = crc_err_i;
      end
   end

   always_ff @(posedge ref_clk_i)
      if (rst_i)
         q_reg <= '0;
      else
         q_reg <= q_next;

   assign frame_o = q_reg.frame;
   assign sof_o   = q_reg.sof;
   assign err_o   = q_reg.err;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   frame_capture_a: assert property (sof_i |=> frame_o == $past(frame_i))
      else $error("frame number not captured");
   error_sync_a: assert property (
      sof_i |=> sof_o && err_o == $past(crc_err_i))
      else $error("frame error not updated with sof flag");
endmodule

// file: uec_ep.sv
// configuration, stall, toggle and flow flags of one endpoint
`timescale 1ns/1ps
`include "uec_defs.svh"
module uec_ep
   import uec_pkg::*;
#(
   parameter bit IS_EP0 = 1'b0
)
(
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   input  wire logic       bus_rst_i,
   input  wire logic       wr_i,
   input  wire logic [7:0] off_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic [7:0] rd_off_i,
   input  wire logic       setup_i,
   input  wire logic       ovf_i,
   input  wire logic       unf_i,
   input  wire logic       tog_adv_i,
   input  wire logic       tog_rx_i,
   input  wire logic [1:0] busy_i,
   output logic      [7:0] rd_o,
   output logic            stall_o,
   output logic            stall_rel_o,
   output logic            on_o,
   output logic            endpoint_memory_allocate_o,
   output logic            tog_o,
   output logic            irq_o
);
   uec_ep_s q_reg;
   uec_ep_s q_next;
   logic    iso;

   assign iso = q_reg.kind == UEC_ISO;

   // toggle advance, then software writes, then other hardware events, bus reset last
   always_comb
   begin
      q_next     = q_reg;
      q_next.rel = 1'b0;
      if (tog_adv_i)
         q_next.tog = q_reg.dir ? ~q_reg.tog : tog_rx_i;
      if (wr_i)
      begin
         case (off_i)
            `UEC_OFF_EP_CTL:
            begin
               q_next.on = wdata_i[`UEC_ENDPOINT_ON_BIT];
               if (wdata_i[`UEC_STALL_REQUEST_BIT])
                  q_next.stall = 1'b1;
               if (wdata_i[`UEC_STALLRC_BIT])
               begin
                  q_next.stall = 1'b0;
                  q_next.rel   = 1'b1;
               end
               if (wdata_i[`UEC_TOGGLE_RESTART_BIT])
                  q_next.tog = 1'b0;
            end
            `UEC_OFF_EP_CFG0:
            begin
               q_next.kind = uec_kind_e'(wdata_i[7:6]);
               q_next.dir  = wdata_i[0] && wdata_i[7:6] != 2'h0;
            end
            `UEC_OFF_EP_CFG1:
            begin
               q_next.size  = wdata_i[6:4];
               q_next.bk    = wdata_i[3:2];
               q_next.endpoint_memory_allocate = wdata_i[`UEC_ENDPOINT_MEMORY_ALLOCATE_BIT];
               q_next.configuration_valid = wdata_i[`UEC_ENDPOINT_MEMORY_ALLOCATE_BIT] &&
                  uec_fits(wdata_i[6:4], wdata_i[3:2], IS_EP0);
            end
            `UEC_OFF_EP_STA:
            begin
               q_next.ovf = q_reg.ovf && wdata_i[`UEC_OVF_BIT];
               q_next.unf = q_reg.unf && wdata_i[`UEC_UNF_BIT];
            end
            `UEC_OFF_EP_IEN:
               q_next.flow_error_irq_enable = wdata_i[`UEC_FLOW_ERROR_IRQ_ENABLE_BIT];
            default:
               q_next.rel = 1'b0;
         endcase
      end
      if (setup_i)
         q_next.stall = 1'b0;
      if (ovf_i && iso)
         q_next.ovf = 1'b1;
      if (unf_i && iso)
         q_next.unf = 1'b1;
      if (bus_rst_i)
         q_next = '0;
   end

   always_ff @(posedge ref_clk_i)
      if (rst_i)
         q_reg <= '0;
      else
         q_reg <= q_next;

   // register read view of this endpoint
   always_comb
   begin
      case (rd_off_i)
         `UEC_OFF_EP_CTL:  rd_o = {2'h0, q_reg.stall, 4'h0, q_reg.on};
         `UEC_OFF_EP_CFG0: rd_o = {q_reg.kind, 5'h00, q_reg.dir};
         `UEC_OFF_EP_CFG1:
            rd_o = {1'b0, q_reg.size, q_reg.bk, q_reg.endpoint_memory_allocate, 1'b0};
         `UEC_OFF_EP_STA:
            rd_o = {q_reg.configuration_valid, q_reg.ovf, q_reg.unf, 2'h0, q_reg.tog,
                    busy_i};
         `UEC_OFF_EP_IEN:  rd_o = {q_reg.flow_error_irq_enable, 7'h00};
         default:          rd_o = 8'h00;
      endcase
   end

   assign stall_o     = q_reg.stall;
   assign stall_rel_o = q_reg.rel;
   assign on_o        = q_reg.on;
   assign endpoint_memory_allocate_o     = q_reg.endpoint_memory_allocate;
   assign tog_o       = q_reg.tog;
   assign irq_o       = q_reg.flow_error_irq_enable && (q_reg.ovf || q_reg.unf);

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   stall_release_a: assert property (
      wr_i && off_i == `UEC_OFF_EP_CTL && wdata_i[`UEC_STALLRC_BIT]
      && !bus_rst_i |=> !stall_o && stall_rel_o ##1 !stall_rel_o)
      else $error("stall release did not clear and self-clear");
   toggle_restart_a: assert property (
      wr_i && off_i == `UEC_OFF_EP_CTL && wdata_i[`UEC_TOGGLE_RESTART_BIT]
      |=> !tog_o)
      else $error("toggle not restarted to data0");
   iso_overflow_a: assert property (
      ovf_i && iso && !bus_rst_i |=> q_reg.ovf)
      else $error("isochronous overflow not flagged");
   cfg_reject_a: assert property (
      wr_i && off_i == `UEC_OFF_EP_CFG1 && wdata_i[6] |=> !q_reg.configuration_valid)
      else $error("reserved size accepted as valid");
   flow_gate_a: assert property (
      !q_reg.flow_error_irq_enable |-> !irq_o)
      else $error("flow interrupt raised while disabled");
endmodule

// file: uec_top.sv
// usb device address, frame and endpoint control over an axi4-lite slave
//
// How it works
// - frame-start and suspend enables gate their flags onto the interrupt.
// - address enable is set by software and cleared only by bus reset.
// - seven-bit device address written by software, cleared by bus reset.
// - frame number of each received frame start is captured, top 3 shown.
// - the frame number is captured even from a corrupted frame start.
// - the low 8 frame number bits read from their own register.
// - frame error flag set when the frame start carries a bad number.
// - frame error and frame-start flag update on the same edge.
// - endpoint select picks the endpoint; values above 4 read zero.
// - one fifo reset bit per endpoint, held until software clears it.
// - stall request set by software, cleared by a received setup.
// - stall release clears the stall and itself after one cycle.
// - toggle restart forces data0 next and reads back as zero.
// - kind decodes control, isochronous, bulk, interrupt from 00..11.
// - direction in only for non-control kinds; control is always out.
// - size codes 0..3 are 8 to 64 bytes; others never fit.
// - bank code 0 single, 1 double; 1x never fits.
// - allocate bit reserves the endpoint memory; clearing frees it.
// - on allocate the configuration valid flag shows if size fits.
// - isochronous overflow and underflow flags; software may only clear.
// - toggle state: last received for out, next to send for in.
// - busy bank count is reported from the transfer engine.
// - frame-start flag set on every detected frame start.
// - flow error enable gates overflow and underflow onto the endpoint interrupt.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "uec_defs.svh"
module uec_top
   import uec_pkg::*;
(
   input  wire logic        REF_CLK_I,
   input  wire logic        RST_I,
   input  wire logic [7:0]  AWADDR_I,
   input  wire logic        AWVALID_I,
   output logic             AWREADY_O,
   input  wire logic [31:0] WDATA_I,
   input  wire logic [3:0]  WSTRB_I,
   input  wire logic        WVALID_I,
   output logic             WREADY_O,
   output logic      [1:0]  BRESP_O,
   output logic             BVALID_O,
   input  wire logic        BREADY_I,
   input  wire logic [7:0]  ARADDR_I,
   input  wire logic        ARVALID_I,
   output logic             ARREADY_O,
   output logic      [31:0] RDATA_O,
   output logic      [1:0]  RRESP_O,
   output logic             RVALID_O,
   input  wire logic        RREADY_I,
   input  wire logic        BUS_RESET_I,
   input  wire logic        SOF_I,
   input  wire logic [10:0] SOF_FRAME_I,
   input  wire logic        SOF_CRC_ERR_I,
   input  wire logic        SUSPEND_I,
   input  wire logic [2:0]  EVT_EP_I,
   input  wire logic        SETUP_I,
   input  wire logic        OVERFLOW_I,
   input  wire logic        UNDERFLOW_I,
   input  wire logic        TOG_ADV_I,
   input  wire logic        TOG_RX_I,
   input  wire logic [9:0]  BUSY_BANKS_I,
   output logic      [6:0]  DEV_ADDR_O,
   output logic             ADDR_EN_O,
   output logic      [4:0]  EP_FIFO_RST_O,
   output logic      [4:0]  EP_STALL_O,
   output logic      [4:0]  EP_STALL_REL_O,
   output logic      [4:0]  EP_ON_O,
   output logic      [4:0]  EP_ENDPOINT_MEMORY_ALLOCATE_O,
   output logic      [4:0]  EP_TOG_O,
   output logic      [4:0]  EP_IRQ_O,
   output logic             USB_IRQ_O
);
   uec_top_s    q_reg;
   uec_top_s    q_next;
   logic        awready;
   logic        wready;
   logic        arready;
   logic        do_wr;
   logic        wr;
   logic        sel_ok;
   logic [10:0] frame;
   logic        sof_flag;
   logic        ferr;
   logic        clr_sof;
   logic        clr_err;
   logic [7:0]  ep_rd [`UEC_NUM_EP];
   logic [7:0]  rd_val;

   // offset decode shared by the read and write paths
   function automatic logic uec_hit(input logic [7:0] a);
      return a[1:0] == 2'h0 && a <= `UEC_OFF_EP_IEN;
   endfunction

   // channel readies and the write strobe
   assign awready = !q_reg.aw_ok && q_reg.wph == UEC_W_IDLE;
   assign wready  = !q_reg.w_ok && q_reg.wph == UEC_W_IDLE;
   assign arready = !q_reg.rvalid;
   assign do_wr   = q_reg.wph == UEC_W_IDLE && q_reg.aw_ok && q_reg.w_ok;
   assign wr      = do_wr && q_reg.wstb && uec_hit(q_reg.awaddr);
   assign sel_ok  = q_reg.sel <= `UEC_EP_MAX;

   // software clear of the frame flags: write zero to the bit
   assign clr_sof = wr && q_reg.awaddr == `UEC_OFF_INT_FLAG &&
                    !q_reg.wdata[`UEC_SOF_BIT];
   assign clr_err = wr && q_reg.awaddr == `UEC_OFF_FERR &&
                    !q_reg.wdata[`UEC_FRAME_COUNT_ERROR_BIT];

   // register read multiplexer
   always_comb
   begin
      case (ARADDR_I)
         `UEC_OFF_INT_FLAG:
            rd_val = {5'h00, sof_flag, 1'b0, q_reg.susp};
         `UEC_OFF_INT_EN:
            rd_val = {5'h00, q_reg.frame_start_irq_enable, 1'b0, q_reg.suspend_irq_enable};
         `UEC_OFF_ADDR:
            rd_val = {q_reg.address_enable, q_reg.addr};
         `UEC_OFF_FNUM_H:
            rd_val = {5'h00, frame[10:8]};
         `UEC_OFF_FNUM_L:
            rd_val = frame[7:0];
         `UEC_OFF_FERR:
            rd_val = {3'h0, ferr, 4'h0};
         `UEC_OFF_SEL:
            rd_val = {5'h00, q_reg.sel};
         `UEC_OFF_FIFO_RST:
            rd_val = {3'h0, q_reg.frst};
         default:
            rd_val = sel_ok ? ep_rd[q_reg.sel] : 8'h00;
      endcase
   end

   // bus channels and general registers
   always_comb
   begin
      q_next = q_reg;
      if (AWVALID_I && awready)
      begin
         q_next.aw_ok  = 1'b1;
         q_next.awaddr = AWADDR_I;
      end
      if (WVALID_I && wready)
      begin
         q_next.w_ok  = 1'b1;
         q_next.wdata = WDATA_I[7:0];
         q_next.wstb  = WSTRB_I[0];
      end
      case (q_reg.wph)
         UEC_W_IDLE:
            if (do_wr)
            begin
               q_next.wph   = UEC_W_RESP;
               q_next.aw_ok = 1'b0;
               q_next.w_ok  = 1'b0;
               q_next.bresp = uec_hit(q_reg.awaddr) ? `UEC_RESP_OK
                                                     : `UEC_RESP_ERR;
            end
         UEC_W_RESP:
            if (BREADY_I)
               q_next.wph = UEC_W_IDLE;
         default:
            q_next.wph = UEC_W_IDLE;
      endcase
      if (q_reg.rvalid && RREADY_I)
         q_next.rvalid = 1'b0;
      if (ARVALID_I && arready)
      begin
         q_next.rvalid = 1'b1;
         q_next.rdata  = uec_hit(ARADDR_I) ? rd_val : 8'h00;
         q_next.rresp  = uec_hit(ARADDR_I) ? `UEC_RESP_OK
                                           : `UEC_RESP_ERR;
      end
      if (wr)
      begin
         case (q_reg.awaddr)
            `UEC_OFF_INT_FLAG:
               q_next.susp = q_reg.susp && q_reg.wdata[`UEC_SUSP_BIT];
            `UEC_OFF_INT_EN:
            begin
               q_next.frame_start_irq_enable  = q_reg.wdata[`UEC_SOF_BIT];
               q_next.suspend_irq_enable = q_reg.wdata[`UEC_SUSP_BIT];
            end
            `UEC_OFF_ADDR:
            begin
               q_next.addr = q_reg.wdata[6:0];
               if (q_reg.wdata[`UEC_ADDRESS_ENABLE_BIT])
                  q_next.address_enable = 1'b1;
            end
            `UEC_OFF_SEL:
               q_next.sel = q_reg.wdata[2:0];
            `UEC_OFF_FIFO_RST:
               q_next.frst = q_reg.wdata[4:0];
            default:
               q_next.sel = q_reg.sel;
         endcase
      end
      // hardware set wins over a same-cycle clear
      if (SUSPEND_I)
         q_next.susp = 1'b1;
      if (BUS_RESET_I)
      begin
         q_next.address_enable = 1'b0;
         q_next.addr  = 7'h00;
      end
   end

   always_ff @(posedge REF_CLK_I)
      if (RST_I)
         q_reg <= '0;
      else
         q_reg <= q_next;

   // frame number and frame-start flags
   uec_frame u_frame (
      .ref_clk_i (REF_CLK_I),
      .rst_i     (RST_I),
      .sof_i     (SOF_I),
      .frame_i   (SOF_FRAME_I),
      .crc_err_i (SOF_CRC_ERR_I),
      .clr_sof_i (clr_sof),
      .clr_err_i (clr_err),
      .frame_o   (frame),
      .sof_o     (sof_flag),
      .err_o     (ferr)
   );

   // one control slice per endpoint, written through the select
   for (genvar i = 0; i < `UEC_NUM_EP; i++)
   begin : g_ep
      uec_ep #(
         .IS_EP0 (i == 0)
      ) u_ep (
         .ref_clk_i   (REF_CLK_I),
         .rst_i       (RST_I),
         .bus_rst_i   (BUS_RESET_I),
         .wr_i        (wr && q_reg.sel == 3'(i)),
         .off_i       (q_reg.awaddr),
         .wdata_i     (q_reg.wdata),
         .rd_off_i    (ARADDR_I),
         .setup_i     (SETUP_I && EVT_EP_I == 3'(i)),
         .ovf_i       (OVERFLOW_I && EVT_EP_I == 3'(i)),
         .unf_i       (UNDERFLOW_I && EVT_EP_I == 3'(i)),
         .tog_adv_i   (TOG_ADV_I && EVT_EP_I == 3'(i)),
         .tog_rx_i    (TOG_RX_I),
         .busy_i      (BUSY_BANKS_I[2*i +: 2]),
         .rd_o        (ep_rd[i]),
         .stall_o     (EP_STALL_O[i]),
         .stall_rel_o (EP_STALL_REL_O[i]),
         .on_o        (EP_ON_O[i]),
         .endpoint_memory_allocate_o     (EP_ENDPOINT_MEMORY_ALLOCATE_O[i]),
         .tog_o       (EP_TOG_O[i]),
         .irq_o       (EP_IRQ_O[i])
      );
   end

   // bus outputs
   assign AWREADY_O = awready;
   assign WREADY_O  = wready;
   assign BVALID_O  = q_reg.wph == UEC_W_RESP;
   assign BRESP_O   = q_reg.bresp;
   assign ARREADY_O = arready;
   assign RVALID_O  = q_reg.rvalid;
   assign RDATA_O   = {24'h000000, q_reg.rdata};
   assign RRESP_O   = q_reg.rresp;

   // link-side outputs
   assign DEV_ADDR_O    = q_reg.addr;
   assign ADDR_EN_O     = q_reg.address_enable;
   assign EP_FIFO_RST_O = q_reg.frst;
   assign USB_IRQ_O     = (sof_flag && q_reg.frame_start_irq_enable) ||
                          (q_reg.susp && q_reg.suspend_irq_enable);

   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);

   addr_enable_hold_a: assert property (
      ADDR_EN_O && !BUS_RESET_I |=> ADDR_EN_O)
      else $error("address enable dropped without bus reset");
   addr_write_a: assert property (
      wr && q_reg.awaddr == `UEC_OFF_ADDR && !BUS_RESET_I
      |=> DEV_ADDR_O == $past(q_reg.wdata[6:0]))
      else $error("device address not written");
   fifo_reset_a: assert property (
      wr && q_reg.awaddr == `UEC_OFF_FIFO_RST
      |=> EP_FIFO_RST_O == $past(q_reg.wdata[4:0]) [*2])
      else $error("fifo reset bits not held");
   sof_irq_a: assert property (
      SOF_I && q_reg.frame_start_irq_enable && !wr |=> USB_IRQ_O)
      else $error("enabled frame start raised no interrupt");
   sof_masked_a: assert property (
      !q_reg.frame_start_irq_enable && !q_reg.susp |-> !USB_IRQ_O)
      else $error("masked frame start raised interrupt");
   read_answer_a: assert property (
      ARVALID_I && ARREADY_O |=> RVALID_O && RDATA_O[31:8] == 24'h000000)
      else $error("read not answered next cycle");
   read_hold_a: assert property (
      RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
      else $error("read data changed before it was taken");
   write_answer_a: assert property (
      do_wr |=> BVALID_O && !AWREADY_O && !WREADY_O)
      else $error("write not answered next cycle");
   select_guard_a: assert property (
      ARVALID_I && ARREADY_O && ARADDR_I >= `UEC_OFF_EP_CTL
      && ARADDR_I <= `UEC_OFF_EP_IEN && !sel_ok |=> RDATA_O == 32'h0)
      else $error("forbidden select returned data");

   write_seen_c: cover property (wr ##[1:4] BVALID_O && BREADY_I);
   read_seen_c: cover property (ARVALID_I && ARREADY_O ##1 RREADY_I);
   sof_error_c: cover property (SOF_I && SOF_CRC_ERR_I ##1 ferr);
endmodule

// file: uec_host_model.sv
// frame start source standing in for the usb host
`timescale 1ns/1ps
module uec_host_model
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        go_i,
   input  wire logic [10:0] frm_i,
   input  wire logic        bad_i,
   output logic             sof_o,
   output logic      [10:0] frame_o,
   output logic             crc_err_o
);
   // one frame start per request; lines scramble between frames
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         sof_o <= 1'b0;
         frame_o <= 11'h000;
         crc_err_o <= 1'b0;
      end
      else
      begin
         sof_o <= go_i;
         frame_o <= go_i ? frm_i : ~frame_o;
         crc_err_o <= go_i ? bad_i : ~crc_err_o;
      end
   end
endmodule

// file: test_uec_top.sv
// self-checking bench of the usb endpoint control block
`timescale 1ns/1ps
module test_uec_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        bus_rst = 1'b0;
   logic        go = 1'b0;
   logic        bad = 1'b0;
   logic [10:0] frm = 11'h000;
   logic [2:0]  ep = 3'h0;
   logic [4:0]  evt = 5'h00; // toggle, setup, overflow, underflow, suspend
   logic [9:0]  busy = 10'h000;
   logic        sof, crc, awready, wready, bvalid, arready, rvalid;
   logic        addr_en, usb_irq;
   logic [10:0] frame;
   logic [1:0]  bresp, rresp, rd_resp;
   logic [31:0] rdata, rd_data;
   logic [4:0]  ep_stall, ep_irq, ep_on, ep_tog, ep_rst, ep_endpoint_memory_allocate;
   logic [6:0]  dev_addr;
   int          miscompares = 0;
   int          compares = 0;
   int          cycles = 0;

   uec_host_model i_uec_host_model (.ref_clk_i(clk), .rst_i(rst), .go_i(go),
      .frm_i(frm), .bad_i(bad), .sof_o(sof), .frame_o(frame), .crc_err_o(crc));
   uec_top i_uec_top (.REF_CLK_I(clk), .RST_I(rst), .AWADDR_I(awaddr),
      .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
      .WSTRB_I(4'hF), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
      .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr),
      .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
      .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
      .BUS_RESET_I(bus_rst), .SOF_I(sof), .SOF_FRAME_I(frame),
      .SOF_CRC_ERR_I(crc), .SUSPEND_I(evt[0]), .EVT_EP_I(ep),
      .SETUP_I(evt[3]), .OVERFLOW_I(evt[2]), .UNDERFLOW_I(evt[1]),
      .TOG_ADV_I(evt[4]), .TOG_RX_I(evt[4]), .BUSY_BANKS_I(busy),
      .DEV_ADDR_O(dev_addr), .ADDR_EN_O(addr_en), .EP_FIFO_RST_O(ep_rst),
      .EP_STALL_O(ep_stall), .EP_STALL_REL_O(), .EP_ON_O(ep_on),
      .EP_ENDPOINT_MEMORY_ALLOCATE_O(ep_endpoint_memory_allocate), .EP_TOG_O(ep_tog), .EP_IRQ_O(ep_irq),
      .USB_IRQ_O(usb_irq));

   // clock and hang guard
   always #20 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         miscompares++;
         summarize();
      end
   end

   task summarize();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         miscompares++;
      end
   endtask

   // write: both channels offered, each released once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ta = 1'b0;
      logic tw = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ta && tw))
      begin
         @(negedge clk);
         ta = ta | (awvalid & awready);
         tw = tw | (wvalid & wready);
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1) @(negedge clk);
      @(posedge clk);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(negedge clk);
      while (arready !== 1'b1) @(negedge clk);
      @(posedge clk);
      arvalid <= 1'b0;
      @(negedge clk);
      while (rvalid !== 1'b1) @(negedge clk);
      rd_data = rdata;
      rd_resp = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      chk(rd_data, {24'h000000, e});
   endtask

   // one-cycle event pulse on the given endpoint
   task automatic ev(input logic [2:0] e, input logic [4:0] v);
      @(posedge clk);
      ep <= e;
      evt <= v;
      @(posedge clk);
      evt <= 5'h00;
      repeat (2) @(posedge clk);
   endtask

   task automatic frame_start(input logic [10:0] f, input logic b);
      @(posedge clk);
      frm <= f;
      bad <= b;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task t_addr();
      rchk(8'h08, 8'h00);
      wr(8'h08, 8'h85);
      rchk(8'h08, 8'h85);
      chk(addr_en, 1'b1);
      wr(8'h08, 8'h05);
      rchk(8'h08, 8'h85);
      chk(dev_addr, 7'h05);
      @(posedge clk);
      bus_rst <= 1'b1;
      @(posedge clk);
      bus_rst <= 1'b0;
      rchk(8'h08, 8'h00);
      chk(ep_on, 5'h00);
      wr(8'h20, 8'h01);
      chk(ep_on, 5'h01);
      rd(8'h34);
      chk(rd_resp, 2'h2);
   endtask

   task t_frame();
      frame_start(11'h5A3, 1'b1);
      rchk(8'h0C, 8'h05);
      rchk(8'h10, 8'hA3);
      rchk(8'h14, 8'h10);
      frame_start(11'h2F0, 1'b0);
      rchk(8'h14, 8'h00);
      rchk(8'h0C, 8'h02);
      ev(3'h0, 5'h01);
      rchk(8'h00, 8'h05);
      wr(8'h04, 8'h01);
      chk(usb_irq, 1'b1);
      wr(8'h00, 8'h00);
      chk(usb_irq, 1'b0);
   endtask

   task t_ep();
      wr(8'h1C, 8'h02);
      chk(ep_rst, 5'h02);
      wr(8'h1C, 8'h00);
      rchk(8'h1C, 8'h00);
      wr(8'h18, 8'h01);
      rchk(8'h18, 8'h01);
      wr(8'h24, 8'h01);
      rchk(8'h24, 8'h00);
      wr(8'h24, 8'h41);
      rchk(8'h24, 8'h41);
      busy <= 10'h008;
      wr(8'h28, 8'h36);
      rchk(8'h2C, 8'h82);
      chk(ep_endpoint_memory_allocate, 5'h02);
      ev(3'h1, 5'h04);
      rchk(8'h2C, 8'hC2);
      wr(8'h30, 8'h80);
      chk(ep_irq, 5'h02);
      wr(8'h2C, 8'hFF);
      rchk(8'h2C, 8'hC2);
      wr(8'h2C, 8'h00);
      rchk(8'h2C, 8'h82);
      chk(ep_irq, 5'h00);
      wr(8'h20, 8'h21);
      chk(ep_stall, 5'h02);
      ev(3'h1, 5'h08);
      rchk(8'h20, 8'h01);
      wr(8'h20, 8'h21);
      wr(8'h20, 8'h11);
      chk(ep_stall, 5'h00);
      ev(3'h1, 5'h10);
      rchk(8'h2C, 8'h86);
      chk(ep_tog, 5'h02);
      wr(8'h20, 8'h09);
      rchk(8'h2C, 8'h82);
      wr(8'h18, 8'h00);
      wr(8'h28, 8'h06);
      rchk(8'h2C, 8'h00);
      chk(ep_endpoint_memory_allocate, 5'h03);
   endtask

   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wr(8'h20, 8'h01);
      t_addr();
      t_frame();
      t_ep();
      summarize();
   end
endmodule
